// [cmp_core_model.sv]
// Behavioural model of the two analog comparator cores
`timescale 1ns/10ps
`default_nettype none

module cmp_core_model (
  input  wire logic [1:0] power_on,
  input  wire logic [1:0] above,
  output logic      [1:0] result
);
  // Unpowered core drives low; no clock here, so results move with the system clock stopped
  assign result = power_on & above;
endmodule // cmp_core_model

`default_nettype wire

// [comp_pkg.sv]
// Constants and types shared by the dual comparator control logic
`default_nettype none

package comp_pkg;

  // ==========================================================================
  // Register addresses, all on one page
  localparam logic [7:0] SFR_PAGE_CMP   = 8'h00;
  localparam logic [7:0] ADDR_CTRL0     = 8'h9A;
  localparam logic [7:0] ADDR_MODE0     = 8'h9B;
  localparam logic [7:0] ADDR_CTRL1     = 8'h9D;
  localparam logic [7:0] ADDR_MODE1     = 8'h9E;
  localparam logic [7:0] ADDR_MUX0      = 8'h9F;
  localparam logic [7:0] ADDR_MUX1      = 8'hA0;

  localparam logic [1:0][7:0] CTRL_ADDR = {ADDR_CTRL1, ADDR_CTRL0};
  localparam logic [1:0][7:0] MODE_ADDR = {ADDR_MODE1, ADDR_MODE0};
  localparam logic [1:0][7:0] MUX_ADDR  = {ADDR_MUX1, ADDR_MUX0};

  // ==========================================================================
  // Field positions
  localparam int EN_BIT      = 7;
  localparam int OUT_BIT     = 6;
  localparam int RISE_BIT    = 5;
  localparam int FALL_BIT    = 4;
  localparam int HYP_LSB     = 2;
  localparam int HYN_LSB     = 0;
  localparam int RIE_BIT     = 5;
  localparam int FIE_BIT     = 4;
  localparam int MD_LSB      = 0;
  localparam int MUX_POS_LSB = 4;
  localparam int MUX_NEG_LSB = 0;

  // ==========================================================================
  // Values after reset
  localparam logic [1:0] HYST_RESET  = 2'h0;
  localparam logic [1:0] SPEED_RESET = 2'h2;
  localparam logic [3:0] SEL_RESET   = 4'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ==========================================================================
  // Per-comparator state
  typedef struct packed {
    logic       en;
    logic [1:0] pos_hyst;
    logic [1:0] neg_hyst;
    logic       rise;
    logic       fall;
    logic       rie;
    logic       fie;
    logic [1:0] speed;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
    logic       s1;
    logic       s2;
    logic       prev;
    logic       latched;
    logic       irq;
  } chan_t;

  localparam chan_t CHAN_RESET = '{en: 1'b0, pos_hyst: HYST_RESET, neg_hyst: HYST_RESET,
                                   rise: 1'b0, fall: 1'b0, rie: 1'b0, fie: 1'b0,
                                   speed: SPEED_RESET, pos_sel: SEL_RESET, neg_sel: SEL_RESET,
                                   s1: 1'b0, s2: 1'b0, prev: 1'b0, latched: 1'b0, irq: 1'b0};

  typedef struct packed {
    chan_t [1:0] ch;
    logic  [7:0] rdata;
  } state_t;

endpackage

`default_nettype wire

// [dual_comparator_control.sv]
// Control and status logic for two identical voltage comparators
`timescale 1ns/10ps
`default_nettype none

module dual_comparator_control
  import comp_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       RST_B,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_PAGE,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  input  wire logic [1:0] CMP_RAW_IN,
  output logic      [1:0] CMP_POWER_ON,
  output logic      [3:0] POS_HYST_SEL,
  output logic      [3:0] NEG_HYST_SEL,
  output logic      [3:0] RESPONSE_SPEED_SEL,
  output logic      [7:0] POS_INPUT_SEL,
  output logic      [7:0] NEG_INPUT_SEL,
  output logic      [1:0] LATCHED_CMP_OUTPUT,
  output logic      [1:0] RAW_CMP_OUTPUT,
  output logic      [1:0] CMP_IRQ
);

  // ==========================================================================
  // Reset release
  logic   rst_b;
  state_t s;
  state_t next_s;

  reset_sync u_reset_sync (
    .clk    (CLOCK),
    .arst_b (RST_B),
    .rst_b  (rst_b)
  );

  // ==========================================================================
  // Helpers
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] page, input logic [7:0] target);
    hit = (addr == target) && (page == SFR_PAGE_CMP);
  endfunction

  function automatic logic [7:0] ctrl_image(input chan_t c);
    logic [7:0] v;
    v = 8'h00;
    v[EN_BIT]            = c.en;
    v[OUT_BIT]           = c.s2;
    v[RISE_BIT]          = c.rise;
    v[FALL_BIT]          = c.fall;
    v[HYP_LSB +: 2]      = c.pos_hyst;
    v[HYN_LSB +: 2]      = c.neg_hyst;
    ctrl_image = v;
  endfunction

  function automatic logic [7:0] mode_image(input chan_t c);
    logic [7:0] v;
    v = 8'h00;
    v[RIE_BIT]      = c.rie;
    v[FIE_BIT]      = c.fie;
    v[MD_LSB +: 2]  = c.speed;
    mode_image = v;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic wr_c;
    logic wr_m;
    logic wr_x;
    logic rise_e;
    logic fall_e;
    wr_c   = 1'b0;
    wr_m   = 1'b0;
    wr_x   = 1'b0;
    rise_e = 1'b0;
    fall_e = 1'b0;
    next_s       = s;
    next_s.rdata = RDATA_RESET;
    for (int i = 0; i < 2; i++) begin
      wr_c = SFR_WR && hit(SFR_ADDR, SFR_PAGE, CTRL_ADDR[i]);
      wr_m = SFR_WR && hit(SFR_ADDR, SFR_PAGE, MODE_ADDR[i]);
      wr_x = SFR_WR && hit(SFR_ADDR, SFR_PAGE, MUX_ADDR[i]);
      // Only the second stage and beyond are looked at
      next_s.ch[i].s1   = CMP_RAW_IN[i];
      next_s.ch[i].s2   = s.ch[i].s1;
      next_s.ch[i].prev = s.ch[i].s2;
      // A disabled core has no meaningful output, so no edges count then
      rise_e = s.ch[i].en && s.ch[i].s2 && !s.ch[i].prev;
      fall_e = s.ch[i].en && !s.ch[i].s2 && s.ch[i].prev;
      if (wr_c) begin
        next_s.ch[i].en       = SFR_WDATA[EN_BIT];
        next_s.ch[i].pos_hyst = SFR_WDATA[HYP_LSB +: 2];
        next_s.ch[i].neg_hyst = SFR_WDATA[HYN_LSB +: 2];
      end
      // Hardware only sets; a new edge beats a software clear
      next_s.ch[i].rise = rise_e || (wr_c ? SFR_WDATA[RISE_BIT] : s.ch[i].rise);
      next_s.ch[i].fall = fall_e || (wr_c ? SFR_WDATA[FALL_BIT] : s.ch[i].fall);
      if (wr_m) begin
        next_s.ch[i].rie   = SFR_WDATA[RIE_BIT];
        next_s.ch[i].fie   = SFR_WDATA[FIE_BIT];
        next_s.ch[i].speed = SFR_WDATA[MD_LSB +: 2];
      end
      if (wr_x) begin
        next_s.ch[i].pos_sel = SFR_WDATA[MUX_POS_LSB +: 4];
        next_s.ch[i].neg_sel = SFR_WDATA[MUX_NEG_LSB +: 4];
      end
      next_s.ch[i].latched = s.ch[i].s2 && next_s.ch[i].en;
      next_s.ch[i].irq = (next_s.ch[i].rise && next_s.ch[i].rie) ||
                         (next_s.ch[i].fall && next_s.ch[i].fie);
      if (SFR_RD && hit(SFR_ADDR, SFR_PAGE, CTRL_ADDR[i])) begin
        next_s.rdata = ctrl_image(s.ch[i]);
      end
      if (SFR_RD && hit(SFR_ADDR, SFR_PAGE, MODE_ADDR[i])) begin
        next_s.rdata = mode_image(s.ch[i]);
      end
      if (SFR_RD && hit(SFR_ADDR, SFR_PAGE, MUX_ADDR[i])) begin
        next_s.rdata = {s.ch[i].pos_sel, s.ch[i].neg_sel};
      end
    end
  end

  always_ff @(posedge CLOCK or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{ch: {CHAN_RESET, CHAN_RESET}, rdata: RDATA_RESET};
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign SFR_RDATA = s.rdata;

  for (genvar g = 0; g < 2; g++) begin : g_out
    assign CMP_POWER_ON[g]                = s.ch[g].en;
    assign POS_HYST_SEL[2*g +: 2]         = s.ch[g].pos_hyst;
    assign NEG_HYST_SEL[2*g +: 2]         = s.ch[g].neg_hyst;
    assign RESPONSE_SPEED_SEL[2*g +: 2]   = s.ch[g].speed;
    assign POS_INPUT_SEL[4*g +: 4]        = s.ch[g].pos_sel;
    assign NEG_INPUT_SEL[4*g +: 4]        = s.ch[g].neg_sel;
    assign LATCHED_CMP_OUTPUT[g]          = s.ch[g].latched;
    assign CMP_IRQ[g]                     = s.ch[g].irq;
    // Deliberately a gate, not a flop: it must work with CLOCK stopped
    assign RAW_CMP_OUTPUT[g]              = CMP_RAW_IN[g] & s.ch[g].en;
  end

  // ==========================================================================
  // Assertions (channel 0, plus off_low_one_a on channel 1; channel 1 is the same logic)
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_b);

  logic wr_ctrl0;
  logic wr_mode0;
  assign wr_ctrl0 = SFR_WR && (SFR_ADDR == ADDR_CTRL0) && (SFR_PAGE == SFR_PAGE_CMP);
  assign wr_mode0 = SFR_WR && (SFR_ADDR == ADDR_MODE0) && (SFR_PAGE == SFR_PAGE_CMP);

  sequence raw_steady_on;
    (s.ch[0].en && !wr_ctrl0 && $stable(CMP_RAW_IN[0])) [*4];
  endsequence

  sequence rise_seen;
    s.ch[0].en && s.ch[0].s2 && !s.ch[0].prev;
  endsequence

  sequence rise_vs_clear;
    s.ch[0].en && s.ch[0].s2 && !s.ch[0].prev && wr_ctrl0 && !SFR_WDATA[RISE_BIT];
  endsequence

  rise_set_a: assert property (rise_seen |=> s.ch[0].rise)
    else $error("rise flag not set after rising edge");
  fall_set_a: assert property (s.ch[0].en && !s.ch[0].s2 && s.ch[0].prev |=> s.ch[0].fall)
    else $error("fall flag not set after falling edge");
  flag_hold_a: assert property (s.ch[0].rise && !wr_ctrl0 |=> s.ch[0].rise)
    else $error("rise flag cleared without a software write");
  set_wins_a: assert property (rise_vs_clear |=> s.ch[0].rise)
    else $error("software clear beat a new rising edge");
  irq_gate_a: assert property (CMP_IRQ[0] == ((s.ch[0].rise && s.ch[0].rie) || (s.ch[0].fall && s.ch[0].fie)))
    else $error("interrupt does not match flags and enables");
  off_low_a: assert property (!CMP_POWER_ON[0] |-> !LATCHED_CMP_OUTPUT[0] && !RAW_CMP_OUTPUT[0])
    else $error("disabled comparator drives its output high");
  enable_write_a: assert property (wr_ctrl0 |=> CMP_POWER_ON[0] == $past(SFR_WDATA[EN_BIT]))
    else $error("enable bit did not follow the write");
  sync_path_a: assert property (raw_steady_on |=> LATCHED_CMP_OUTPUT[0] == $past(CMP_RAW_IN[0]))
    else $error("latched output does not follow a steady raw result");
  speed_write_a: assert property (wr_mode0 |=> RESPONSE_SPEED_SEL[1:0] == $past(SFR_WDATA[1:0]))
    else $error("response speed did not follow the mode write");
  result_read_a: assert property (SFR_RD && SFR_ADDR == ADDR_CTRL0 && SFR_PAGE == SFR_PAGE_CMP
                                  |=> SFR_RDATA[OUT_BIT] == $past(s.ch[0].s2))
    else $error("output state bit does not show the comparison result");
  fall_hold_a: assert property (s.ch[0].fall && !wr_ctrl0 |=> s.ch[0].fall)
    else $error("fall flag cleared without a software write");
  pos_hyst_a: assert property (wr_ctrl0 |=> POS_HYST_SEL[1:0] == $past(SFR_WDATA[HYP_LSB +: 2]))
    else $error("positive hysteresis code did not follow the control write");
  neg_hyst_a: assert property (wr_ctrl0 |=> NEG_HYST_SEL[1:0] == $past(SFR_WDATA[HYN_LSB +: 2]))
    else $error("negative hysteresis code did not follow the control write");
  read_idle_a: assert property (!SFR_RD |=> SFR_RDATA == RDATA_RESET)
    else $error("read data not idle without a read");
  off_low_one_a: assert property (!CMP_POWER_ON[1] |-> !LATCHED_CMP_OUTPUT[1] && !RAW_CMP_OUTPUT[1])
    else $error("disabled comparator one drives its output high");

endmodule // dual_comparator_control

`default_nettype wire

// [reset_sync.sv]
// Two-stage release synchroniser for the active-low reset
`timescale 1ns/10ps
`default_nettype none

module reset_sync (
  input  wire logic clk,
  input  wire logic arst_b,
  output logic      rst_b
);

  logic [1:0] q;
  logic [1:0] next_q;

  always_comb begin
    next_q = {q[0], 1'b1};
  end

  // Assertion is immediate, release waits two edges
  always_ff @(posedge clk or negedge arst_b) begin
    if (!arst_b) begin
      q <= 2'h0;
    end else begin
      q <= next_q;
    end
  end

  assign rst_b = q[1];

endmodule // reset_sync

`default_nettype wire

// [tb.sv]
// Self-checking testbench for the dual comparator control block
`timescale 1ns/10ps
`default_nettype none

module tb;
  import comp_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals
  logic       clock     = 1'b0;
  logic       run       = 1'b1;
  logic       rst_b     = 1'b0;
  logic [7:0] sfr_addr  = 8'h00;
  logic [7:0] sfr_page  = 8'h00;
  logic       sfr_wr    = 1'b0;
  logic       sfr_rd    = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [1:0] above     = 2'h0;
  logic [7:0] sfr_rdata, pos_sel, neg_sel;
  logic [1:0] raw_in, power_on, latched, raw_out, irq;
  logic [3:0] pos_hyst, neg_hyst, speed;
  int         err_total  = 0;
  int         n_compared = 0;

  // Clock can be halted to show the raw path needs none
  initial forever begin
    #20;
    if (run) clock = ~clock;
  end

  dual_comparator_control u_dual_comparator_control (
    .CLOCK(clock), .RST_B(rst_b), .SFR_ADDR(sfr_addr), .SFR_PAGE(sfr_page),
    .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
    .CMP_RAW_IN(raw_in), .CMP_POWER_ON(power_on), .POS_HYST_SEL(pos_hyst),
    .NEG_HYST_SEL(neg_hyst), .RESPONSE_SPEED_SEL(speed), .POS_INPUT_SEL(pos_sel),
    .NEG_INPUT_SEL(neg_sel), .LATCHED_CMP_OUTPUT(latched), .RAW_CMP_OUTPUT(raw_out), .CMP_IRQ(irq));
  cmp_core_model u_cmp_core_model (.power_on(power_on), .above(above), .result(raw_in));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
    // Registered outputs only settle after the edge that takes the write
    #1;
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1;
    chk(what, sfr_rdata, exp);
  endtask

  task automatic wait_sync;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic reset_values;
    for (int c = 0; c < 2; c++) begin
      rd("ctrl", CTRL_ADDR[c], 8'h00);
      rd("mode", MODE_ADDR[c], 8'h02);
      rd("mux", MUX_ADDR[c], 8'h00);
    end
    chk("speed", {4'h0, speed}, 8'h0A);
    rd("unmapped", 8'h9C, 8'h00);
    @(posedge clock);
    sfr_page <= 8'h01;
    wr(ADDR_CTRL0, 8'h80);
    @(posedge clock);
    sfr_page <= 8'h00;
    rd("page", ADDR_CTRL0, 8'h00);
    chk("power", {6'h0, power_on}, 8'h00);
    $display("test reset_values done");
  endtask

  task automatic fields(input int c);
    logic [1:0] h;
    for (int v = 0; v < 4; v++) begin
      h = v[1:0];
      // Bit 6 is read-only, so the one written there must not come back
      wr(CTRL_ADDR[c], {4'h4, h, ~h});
      rd("ctrl", CTRL_ADDR[c], {4'h0, h, ~h});
      chk("hyp", {6'h0, pos_hyst[2*c+:2]}, {6'h0, h});
      chk("hyn", {6'h0, neg_hyst[2*c+:2]}, {6'h0, ~h});
      wr(MODE_ADDR[c], {6'h3F, h});
      rd("mode", MODE_ADDR[c], {6'h0C, h});
      chk("speed", {6'h0, speed[2*c+:2]}, {6'h0, h});
      wr(MUX_ADDR[c], {h, 2'h1, ~h, 2'h2});
      chk("psel", {4'h0, pos_sel[4*c+:4]}, {4'h0, h, 2'h1});
      chk("nsel", {4'h0, neg_sel[4*c+:4]}, {4'h0, ~h, 2'h2});
    end
    $display("test fields %0d done", c);
  endtask

  task automatic edges(input int c);
    wr(CTRL_ADDR[c], 8'h80);
    chk("power", {7'h0, power_on[c]}, 8'h01);
    @(posedge clock);
    above[c] <= 1'b1;
    #1;
    chk("raw", {7'h0, raw_out[c]}, 8'h01);
    wait_sync;
    chk("latched", {7'h0, latched[c]}, 8'h01);
    rd("rise", CTRL_ADDR[c], 8'hE0);
    chk("irq", {7'h0, irq[c]}, 8'h01);
    wr(CTRL_ADDR[c], 8'h80);
    rd("clr", CTRL_ADDR[c], 8'hC0);
    chk("irq", {7'h0, irq[c]}, 8'h00);
    wr(MODE_ADDR[c], 8'h12);
    @(posedge clock);
    above[c] <= 1'b0;
    wait_sync;
    repeat (10) @(posedge clock);
    rd("fall", CTRL_ADDR[c], 8'h90);
    chk("irq", {7'h0, irq[c]}, 8'h01);
    wr(MODE_ADDR[c], 8'h22);
    chk("mask", {7'h0, irq[c]}, 8'h00);
    @(posedge clock);
    above[c] <= 1'b1;
    repeat (2) @(posedge clock);
    sfr_addr  <= CTRL_ADDR[c];
    sfr_wdata <= 8'h80;
    sfr_wr    <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
    rd("setwins", CTRL_ADDR[c], 8'hE0);
    chk("irq", {7'h0, irq[c]}, 8'h01);
    wr(CTRL_ADDR[c], 8'h00);
    wait_sync;
    chk("off", {5'h0, power_on[c], latched[c], raw_out[c]}, 8'h00);
    above[c] <= 1'b0;
    wr(MODE_ADDR[c], 8'h02);
    $display("test edges %0d done", c);
  endtask

  task automatic clock_stopped;
    wr(ADDR_CTRL0, 8'h80);
    @(posedge clock);
    run = 1'b0;
    #100;
    above[0] = 1'b1;
    #1;
    chk("raw stop", {7'h0, raw_out[0]}, 8'h01);
    above[0] = 1'b0;
    #1;
    chk("raw stop", {7'h0, raw_out[0]}, 8'h00);
    run = 1'b1;
    wr(ADDR_CTRL0, 8'h00);
    $display("test clock_stopped done");
  endtask

  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    reset_values();
    for (int c = 0; c < 2; c++) begin
      fields(c);
      edges(c);
    end
    clock_stopped();
    wrap_up();
  end

  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
endmodule // tb

`default_nettype wire
